/* src/serial_ports_pkg.sv */
// Shared constants and types for the three asynchronous serial ports
package serial_ports_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned DEFAULT_BPS = 115_200;
	localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / DEFAULT_BPS); // Clocks per bit
	localparam logic [15:0] DIV_MIN = 16'h0008;         // Shorter lows are glitches
	localparam logic [15:0] MEAS_MAX = 16'hFFFF;        // Measurement saturates here

	// ------------------------------------------------------------
	// Framing and sequencing counts
	// ------------------------------------------------------------
	localparam logic [3:0] FRAME_LAST = 4'h9;           // Start + 8 data + stop, last index
	localparam logic [3:0] SKIP_BITS = 4'h8;            // Whole bits skipped after first rise
	localparam logic [2:0] REPLY_LEN = 3'h4;            // Lock reply length in bytes
	localparam int FIFO_DEPTH = 4;
	localparam int DATA_W = 8;
	localparam int NPORTS = 3;

	// ------------------------------------------------------------
	// Characters
	// ------------------------------------------------------------
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_O = 8'h4F;
	localparam logic [7:0] CH_K = 8'h4B;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CASE_BIT = 8'h20;

	// Rate adaptation states
	typedef enum logic [3:0] {
		AB_MEASURE = 4'b0001,
		AB_SKIP = 4'b0010,
		AB_CHECK = 4'b0100,
		AB_LOCKED = 4'b1000
	} autobaud_state_t;

endpackage : serial_ports_pkg

/* src/stream_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [DEPTH-1:0][WIDTH-1:0] mem_r, mem_nxt;
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
		bump = (idx == LAST_IDX) ? '0 : idx + 1'b1;
	endfunction : bump

	// Honest flags: ready only with room, valid only with data
	assign in_ready_out = (cnt_r != FULL_CNT);
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out = mem_r[rd_r];
	assign push = clk_en_in && in_valid_in && in_ready_out;
	assign pop = clk_en_in && out_valid_out && out_ready_in;

	// Next pointers, count and storage
	always_comb begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = in_data_in;
			wr_nxt = bump(wr_r);
		end
		if (pop) begin
			rd_nxt = bump(rd_r);
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// Register stage; storage needs no reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else if (clk_en_in) begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
		if (clk_en_in) begin
			mem_r <= mem_nxt;
		end
	end

	a_fifo_count_bound: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cnt_r <= FULL_CNT) else $error("FIFO count above depth");
	a_fifo_push_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(push && !pop) |=> cnt_r == $past(cnt_r) + 1'b1) else $error("FIFO push lost");

endmodule : stream_fifo

/* src/autobaud_serial_ports.sv */
// Main port with rate adaptation, plus debug log and auxiliary log ports

// Overview of operation
// - Three independent serial ports, device side of link
// - Main port adapts rate after reset, default 115200
// - After lock, device replies OK at locked rate
// - Hibernation keeps locked rate, no new synchronisation
// - Debug log port runs at 115200 bps
// - Auxiliary log port runs at 115200 bps
// - Main port carries commands, data and upgrades
module autobaud_serial_ports import serial_ports_pkg::*; (
	// Clock, reset, enable, power state
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic hibernate_in,
	// Serial lines
	input wire logic main_port_rx_in,
	output logic main_port_tx_out,
	input wire logic log_port_rx_in,
	output logic log_port_tx_out,
	input wire logic aux_port_rx_in,
	output logic aux_port_tx_out,
	// Main port user side
	input wire logic main_tx_valid_in,
	input wire logic [7:0] main_tx_data_in,
	output logic main_tx_ready_out,
	output logic main_rx_valid_out,
	output logic [7:0] main_rx_data_out,
	output logic rate_locked_out,
	output logic [15:0] rate_div_out,
	// Debug log port user side
	input wire logic log_tx_valid_in,
	input wire logic [7:0] log_tx_data_in,
	output logic log_tx_ready_out,
	output logic log_rx_valid_out,
	output logic [7:0] log_rx_data_out,
	// Auxiliary log port user side
	input wire logic aux_tx_valid_in,
	input wire logic [7:0] aux_tx_data_in,
	output logic aux_tx_ready_out,
	output logic aux_rx_valid_out,
	output logic [7:0] aux_rx_data_out
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic active;
	logic [NPORTS-1:0] rx_line, tx_src_valid, tx_load, rx_done, rx_en;
	logic [NPORTS-1:0][7:0] tx_src_data;
	logic [NPORTS-1:0][15:0] div;
	logic [NPORTS-1:0] tx_busy_r, tx_busy_nxt, rx_busy_r, rx_busy_nxt;
	logic [NPORTS-1:0] rx_valid_r, rx_valid_nxt;
	logic [NPORTS-1:0][15:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
	logic [NPORTS-1:0][3:0] tx_bit_r, tx_bit_nxt, rx_bit_r, rx_bit_nxt;
	logic [NPORTS-1:0][9:0] tx_sh_r, tx_sh_nxt;
	logic [NPORTS-1:0][7:0] rx_sh_r, rx_sh_nxt, rx_data_r, rx_data_nxt;
	autobaud_state_t ab_r, ab_nxt;
	logic [15:0] meas_r, meas_nxt, cand_r, cand_nxt;
	logic [3:0] skip_r, skip_nxt;
	logic [2:0] reply_r, reply_nxt;
	logic reply_busy, fifo_valid, fifo_ready;
	logic [7:0] fifo_data;

	function automatic logic [15:0] half(input logic [15:0] d);
		half = {1'b0, d[15:1]};
	endfunction : half

	function automatic logic is_ch(input logic [7:0] b, input logic [7:0] c);
		is_ch = ((b | CASE_BIT) == (c | CASE_BIT));
	endfunction : is_ch

	function automatic logic [7:0] reply_char(input logic [2:0] idx);
		case (idx)
			3'h0: reply_char = CH_O;
			3'h1: reply_char = CH_K;
			3'h2: reply_char = CH_CR;
			default: reply_char = CH_LF;
		endcase
	endfunction : reply_char

	// ------------------------------------------------------------
	// Port wiring and transmit sources
	// ------------------------------------------------------------
	// Hibernation idles the engines but never touches the locked rate
	assign active = clk_en_in && !hibernate_in;
	assign rx_line = {aux_port_rx_in, log_port_rx_in, main_port_rx_in};
	assign main_port_tx_out = tx_sh_r[0][0];
	assign log_port_tx_out = tx_sh_r[1][0];
	assign aux_port_tx_out = tx_sh_r[2][0];
	// Main rate follows the candidate in the check and locked states; log ports stay fixed
	assign div[0] = (ab_r == AB_CHECK || ab_r == AB_LOCKED) ? cand_r : DIV_DEFAULT;
	assign div[1] = DIV_DEFAULT;
	assign div[2] = DIV_DEFAULT;
	assign reply_busy = (ab_r == AB_LOCKED) && (reply_r != REPLY_LEN);
	// Reply goes out before any queued user byte
	assign tx_src_valid[0] = reply_busy || ((ab_r == AB_LOCKED) && fifo_valid);
	assign tx_src_data[0] = reply_busy ? reply_char(reply_r) : fifo_data;
	assign tx_src_valid[1] = log_tx_valid_in;
	assign tx_src_data[1] = log_tx_data_in;
	assign tx_src_valid[2] = aux_tx_valid_in;
	assign tx_src_data[2] = aux_tx_data_in;
	assign fifo_ready = tx_load[0] && !reply_busy;
	assign log_tx_ready_out = active && !tx_busy_r[1];
	assign aux_tx_ready_out = active && !tx_busy_r[2];
	// Main receiver is held off while the rate is still being measured
	assign rx_en = {2'b11, (ab_r == AB_CHECK) || (ab_r == AB_LOCKED)};
	assign main_rx_valid_out = rx_valid_r[0];
	assign main_rx_data_out = rx_data_r[0];
	assign log_rx_valid_out = rx_valid_r[1];
	assign log_rx_data_out = rx_data_r[1];
	assign aux_rx_valid_out = rx_valid_r[2];
	assign aux_rx_data_out = rx_data_r[2];
	assign rate_locked_out = (ab_r == AB_LOCKED);
	assign rate_div_out = cand_r;

	// Queue for outgoing main port traffic; full stalls the user
	stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_main_tx_fifo (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.in_valid_in(main_tx_valid_in),
		.in_data_in(main_tx_data_in),
		.in_ready_out(main_tx_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(fifo_ready)
	);

	// ------------------------------------------------------------
	// Transmit and receive engines, one per port
	// ------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			tx_busy_nxt[p] = tx_busy_r[p];
			tx_cnt_nxt[p] = tx_cnt_r[p];
			tx_bit_nxt[p] = tx_bit_r[p];
			tx_sh_nxt[p] = tx_sh_r[p];
			tx_load[p] = active && !tx_busy_r[p] && tx_src_valid[p];
			rx_busy_nxt[p] = rx_busy_r[p];
			rx_cnt_nxt[p] = rx_cnt_r[p];
			rx_bit_nxt[p] = rx_bit_r[p];
			rx_sh_nxt[p] = rx_sh_r[p];
			rx_data_nxt[p] = rx_data_r[p];
			rx_valid_nxt[p] = 1'b0;
			rx_done[p] = 1'b0;
			if (hibernate_in) begin
				tx_busy_nxt[p] = 1'b0;
				tx_sh_nxt[p] = '1;
				rx_busy_nxt[p] = 1'b0;
			end else begin
				// Line idles high; stop bit is shifted in from the top
				if (tx_load[p]) begin
					tx_busy_nxt[p] = 1'b1;
					tx_sh_nxt[p] = {1'b1, tx_src_data[p], 1'b0};
					tx_bit_nxt[p] = '0;
					tx_cnt_nxt[p] = div[p] - 16'h0001;
				end else if (tx_busy_r[p]) begin
					if (tx_cnt_r[p] != '0) begin
						tx_cnt_nxt[p] = tx_cnt_r[p] - 16'h0001;
					end else begin
						tx_sh_nxt[p] = {1'b1, tx_sh_r[p][9:1]};
						tx_cnt_nxt[p] = div[p] - 16'h0001;
						tx_bit_nxt[p] = tx_bit_r[p] + 4'h1;
						tx_busy_nxt[p] = (tx_bit_r[p] != FRAME_LAST);
					end
				end
				// Receiver samples each bit at its centre
				if (!rx_busy_r[p]) begin
					if (rx_en[p] && !rx_line[p]) begin
						rx_busy_nxt[p] = 1'b1;
						rx_bit_nxt[p] = '0;
						rx_cnt_nxt[p] = half(div[p]);
					end
				end else if (rx_cnt_r[p] != '0) begin
					rx_cnt_nxt[p] = rx_cnt_r[p] - 16'h0001;
				end else begin
					rx_cnt_nxt[p] = div[p] - 16'h0001;
					rx_bit_nxt[p] = rx_bit_r[p] + 4'h1;
					if (rx_bit_r[p] == '0) begin
						rx_busy_nxt[p] = !rx_line[p]; // False start is dropped
					end else if (rx_bit_r[p] != FRAME_LAST) begin
						rx_sh_nxt[p] = {rx_line[p], rx_sh_r[p][7:1]};
					end else begin
						// Bad stop bit discards the byte
						rx_busy_nxt[p] = 1'b0;
						rx_done[p] = rx_line[p];
						rx_data_nxt[p] = rx_line[p] ? rx_sh_r[p] : rx_data_r[p];
						rx_valid_nxt[p] = rx_line[p] && (p != 0 || ab_r == AB_LOCKED);
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			tx_busy_r <= '0;
			tx_cnt_r <= '0;
			tx_bit_r <= '0;
			tx_sh_r <= '1;
			rx_busy_r <= '0;
			rx_cnt_r <= '0;
			rx_bit_r <= '0;
			rx_sh_r <= '0;
			rx_data_r <= '0;
			rx_valid_r <= '0;
		end else if (clk_en_in) begin
			tx_busy_r <= tx_busy_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_sh_r <= tx_sh_nxt;
			rx_busy_r <= rx_busy_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_data_r <= rx_data_nxt;
			rx_valid_r <= rx_valid_nxt;
		end
	end

	// ------------------------------------------------------------
	// Rate adaptation
	// ------------------------------------------------------------
	// The start bit of 'A' or 'a' is one bit long because bit 0 is set;
	// its width gives the rate, then the following 'T' confirms it.
	always_comb begin
		ab_nxt = ab_r;
		meas_nxt = meas_r;
		cand_nxt = cand_r;
		skip_nxt = skip_r;
		reply_nxt = reply_r;
		if (active) begin
			case (ab_r)
				AB_MEASURE: begin
					if (!rx_line[0]) begin
						meas_nxt = (meas_r == MEAS_MAX) ? meas_r : meas_r + 16'h0001;
					end else if (meas_r != '0) begin
						meas_nxt = '0;
						if (meas_r >= DIV_MIN) begin
							cand_nxt = meas_r;
							meas_nxt = half(meas_r);
							skip_nxt = '0;
							ab_nxt = AB_SKIP;
						end
					end
				end
				AB_SKIP: begin
					// Wait to the middle of the stop bit of the measured byte
					if (meas_r != '0) begin
						meas_nxt = meas_r - 16'h0001;
					end else if (skip_r == SKIP_BITS) begin
						ab_nxt = AB_CHECK;
					end else begin
						meas_nxt = cand_r - 16'h0001;
						skip_nxt = skip_r + 4'h1;
					end
				end
				AB_CHECK: begin
					// Host keeps repeating, so a miss just restarts measurement
					if (rx_done[0]) begin
						meas_nxt = '0;
						if (is_ch(rx_sh_r[0], CH_T)) begin
							ab_nxt = AB_LOCKED;
							reply_nxt = '0;
						end else begin
							ab_nxt = AB_MEASURE;
						end
					end
				end
				AB_LOCKED: begin
					if (tx_load[0] && reply_busy) begin
						reply_nxt = reply_r + 3'h1;
					end
				end
				default: ab_nxt = AB_MEASURE;
			endcase
		end
	end

	// Only reset re-enters adaptation; hibernation leaves this alone
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ab_r <= AB_MEASURE;
			meas_r <= '0;
			cand_r <= DIV_DEFAULT;
			skip_r <= '0;
			reply_r <= REPLY_LEN;
		end else if (clk_en_in) begin
			ab_r <= ab_nxt;
			meas_r <= meas_nxt;
			cand_r <= cand_nxt;
			skip_r <= skip_nxt;
			reply_r <= reply_nxt;
		end
	end

	// ------------------------------------------------------------
	// Assertions and covers
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_reset_adaptive: assert property ($fell(rst_in) |-> ab_r == AB_MEASURE
		&& cand_r == DIV_DEFAULT) else $error("Main port not adaptive after reset");
	a_lock_on_at: assert property ((ab_r == AB_CHECK && active && rx_done[0]
		&& is_ch(rx_sh_r[0], CH_T)) |=> rate_locked_out && reply_r == '0)
		else $error("Confirmed rate did not lock");
	a_reply_first: assert property (fifo_ready |-> reply_r == REPLY_LEN)
		else $error("User data sent before reply");
	a_hib_keeps_rate: assert property ((hibernate_in && rate_locked_out)
		|=> rate_locked_out && $stable(cand_r)) else $error("Hibernation lost rate");
	a_log_start_bit: assert property (tx_load[1] |=> !log_port_tx_out
		&& div[1] == DIV_DEFAULT) else $error("Log port frame start wrong");
	a_aux_start_bit: assert property (tx_load[2] |=> !aux_port_tx_out
		&& div[2] == DIV_DEFAULT) else $error("Aux port frame start wrong");
	a_main_rx_forward: assert property (main_rx_valid_out
		|-> $past(ab_r) == AB_LOCKED) else $error("Main byte forwarded before lock");
	a_tx_idle_high: assert property ((!tx_busy_r[0] && !tx_busy_r[1]
		&& !tx_busy_r[2]) |-> main_port_tx_out && log_port_tx_out && aux_port_tx_out)
		else $error("Idle line not high");
	a_tx_stop_high: assert property ((tx_busy_r[1] && tx_bit_r[1] == FRAME_LAST)
		|-> log_port_tx_out) else $error("Stop bit not high");
	a_ports_apart: assert property ((tx_load[1] && !tx_busy_r[0])
		|=> main_port_tx_out || tx_busy_r[0]) else $error("Ports not independent");

	c_rate_locked: cover property ($rose(rate_locked_out));
	c_reply_done: cover property (rate_locked_out && $changed(reply_r) && reply_r == REPLY_LEN);
	c_hibernate_locked: cover property (rate_locked_out && $fell(hibernate_in));
	c_log_rx_byte: cover property (log_rx_valid_out);

endmodule : autobaud_serial_ports

/* sim/host_model.sv */
// Behavioural host terminal facing the three device serial ports
module host_model (
	// Clock
	input wire logic sys_clk_in,
	// Device transmit lines, bit 0 main, 1 log, 2 aux
	input wire logic [2:0] dev_tx_in,
	// Device receive lines, same order
	output logic [2:0] dev_rx_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Host TX drives device RX, lines idle high between frames
	initial dev_rx_out = 3'b111;

	// One frame: start low, data LSB first, stop high, no parity
	task automatic send_byte(input int idx, input logic [7:0] data, input int div);
		logic [9:0] frame;
		frame = {1'b1, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge sys_clk_in);
			dev_rx_out[idx] = frame[i];
			repeat (div - 1) @(negedge sys_clk_in);
		end
	endtask : send_byte

	// Sample each bit at its centre; ok is low on a bad start or stop
	task automatic recv_byte(input int idx, input int div, output logic [7:0] data,
			output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		data = 8'h00;
		while (dev_tx_in[idx] !== 1'b0 && n < 200000) begin
			@(negedge sys_clk_in);
			n++;
		end
		if (n < 200000) begin
			repeat (div / 2) @(negedge sys_clk_in);
			ok = (dev_tx_in[idx] === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (div) @(negedge sys_clk_in);
				data[i] = dev_tx_in[idx];
			end
			repeat (div) @(negedge sys_clk_in);
			ok = ok & (dev_tx_in[idx] === 1'b1);
		end
	endtask : recv_byte

endmodule : host_model

/* sim/testbench.sv */
// Self-checking bench for the three serial ports and the main port rate lock
module testbench
	import serial_ports_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	localparam int HOST_DIV = 16; // Fast host rate keeps the run short
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic clk_en_in = 1'b1;
	logic hibernate = 1'b0;
	logic [2:0] host_tx;
	logic [2:0] dev_tx;
	logic [2:0] tx_v = 3'b000;
	logic [7:0] tx_d [3] = '{8'h00, 8'h00, 8'h00};
	logic [2:0] tx_rdy;
	logic [2:0] rx_v;
	logic [7:0] rx_d [3];
	logic rate_locked;
	logic [15:0] rate_div;
	logic [7:0] last_rx [3];
	int rx_cnt [3] = '{0, 0, 0};
	logic [31:0] lfsr_r = 32'h97FF;
	int n_fail = 0;
	int total_checks = 0;

	always #10 sys_clk_in = ~sys_clk_in;

	host_model host (.sys_clk_in(sys_clk_in), .dev_tx_in(dev_tx), .dev_rx_out(host_tx));

	autobaud_serial_ports uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
		.hibernate_in(hibernate), .main_port_rx_in(host_tx[0]), .main_port_tx_out(dev_tx[0]),
		.log_port_rx_in(host_tx[1]), .log_port_tx_out(dev_tx[1]),
		.aux_port_rx_in(host_tx[2]), .aux_port_tx_out(dev_tx[2]),
		.main_tx_valid_in(tx_v[0]), .main_tx_data_in(tx_d[0]), .main_tx_ready_out(tx_rdy[0]),
		.main_rx_valid_out(rx_v[0]), .main_rx_data_out(rx_d[0]),
		.rate_locked_out(rate_locked), .rate_div_out(rate_div),
		.log_tx_valid_in(tx_v[1]), .log_tx_data_in(tx_d[1]), .log_tx_ready_out(tx_rdy[1]),
		.log_rx_valid_out(rx_v[1]), .log_rx_data_out(rx_d[1]),
		.aux_tx_valid_in(tx_v[2]), .aux_tx_data_in(tx_d[2]), .aux_tx_ready_out(tx_rdy[2]),
		.aux_rx_valid_out(rx_v[2]), .aux_rx_data_out(rx_d[2]));

	// Capture received bytes; the valid pulse stands one cycle only
	always @(posedge sys_clk_in) begin
		for (int k = 0; k < 3; k++) begin
			if (rx_v[k] === 1'b1) begin
				last_rx[k] <= rx_d[k];
				rx_cnt[k] <= rx_cnt[k] + 1;
			end
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Fixed-seed shift register keeps every run identical
	function automatic logic [7:0] rnd();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r[7:0];
	endfunction : rnd

	// Whole frame in clocks: start, eight data and stop, each one divisor long
	function automatic int frame_cycles(input int div);
		return (int'(FRAME_LAST) + 1) * div;
	endfunction : frame_cycles

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
			n_fail++;
		end
	endtask : chk

	task automatic test_done();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	// Offer a byte and hold it until ready is seen at the taking edge
	task automatic push(input int p, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge sys_clk_in);
		tx_v[p] = 1'b1;
		tx_d[p] = d;
		while (tx_rdy[p] !== 1'b1 && n < 10000) begin
			@(negedge sys_clk_in);
			n++;
		end
		chk(16'(n < 10000), 16'h0001, "push timed out");
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		tx_v[p] = 1'b0;
	endtask : push

	// Device sends one byte; on log ports the busy span must be ten bits
	task automatic tx_frame(input int p, input int div, input logic [7:0] d);
		logic [7:0] got;
		logic ok;
		int n;
		fork
			begin
				push(p, d);
				// Push returns half a cycle after the taking edge; count from there
				n = 0;
				while (p != 0 && tx_rdy[p] === 1'b0 && n < 9000) begin
					@(negedge sys_clk_in);
					n++;
				end
				if (p != 0) chk(16'(n), 16'(frame_cycles(div)), "busy span");
			end
			host.recv_byte(p, div, got, ok);
		join
		chk(16'(ok), 16'h0001, "tx framing");
		chk(16'(got), 16'(d), "tx data");
	endtask : tx_frame

	// Host sends one byte; exactly one receive pulse with that byte
	task automatic rx_frame(input int p, input int div, input logic [7:0] d);
		int c0;
		c0 = rx_cnt[p];
		host.send_byte(p, d, div);
		repeat (div) @(negedge sys_clk_in);
		chk(16'(rx_cnt[p] - c0), 16'h0001, "rx pulse count");
		chk(16'(last_rx[p]), 16'(d), "rx data");
	endtask : rx_frame

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [7:0] exp_q [8];
		logic [7:0] got;
		logic ok;
		repeat (8) @(negedge sys_clk_in);
		rst_in = 1'b0;
		// Reset leaves lines idle and the main port at the default rate
		chk(16'(dev_tx), 16'h0007, "idle lines");
		chk(16'(rate_locked), 16'h0000, "lock after reset");
		chk(rate_div, DIV_DEFAULT, "default divisor");
		// Log and aux ports at the default rate, both directions
		for (int p = 1; p < 3; p++) begin
			tx_frame(p, DIV_DEFAULT, rnd());
			rx_frame(p, DIV_DEFAULT, rnd());
		end
		// Clock enable low stalls the log transmitter
		clk_en_in = 1'b0;
		@(negedge sys_clk_in);
		chk(16'(tx_rdy[2:1]), 16'h0000, "ready while frozen");
		clk_en_in = 1'b1;
		// A line whose second character is wrong must not lock; host repeats
		host.send_byte(0, 8'h41, HOST_DIV);
		host.send_byte(0, 8'h58, HOST_DIV);
		repeat (40) @(negedge sys_clk_in);
		chk(16'(rate_locked), 16'h0000, "lock on bad line");
		chk(16'(rx_cnt[0]), 16'h0000, "main output before lock");
		// Four queued bytes fill the FIFO, which then refuses, nothing drains
		for (int i = 0; i < 4; i++) begin
			exp_q[i + 4] = rnd();
			push(0, exp_q[i + 4]);
		end
		chk(16'(tx_rdy[0]), 16'h0000, "full FIFO refuses");
		chk(16'(dev_tx[0]), 16'h0001, "main idle before lock");
		exp_q[0] = CH_O;
		exp_q[1] = CH_K;
		exp_q[2] = CH_CR;
		exp_q[3] = CH_LF;
		// Good line locks; reply then queued bytes at the host rate
		fork
			begin
				host.send_byte(0, 8'h41, HOST_DIV);
				host.send_byte(0, 8'h54, HOST_DIV);
			end
			for (int i = 0; i < 8; i++) begin
				host.recv_byte(0, HOST_DIV, got, ok);
				chk(16'({ok, got}), 16'({1'b1, exp_q[i]}), "reply and queue");
			end
		join
		chk(16'(rate_locked), 16'h0001, "locked");
		chk(rate_div, 16'(HOST_DIV), "locked divisor");
		// Data both ways at the locked rate
		rx_frame(0, HOST_DIV, rnd());
		tx_frame(0, HOST_DIV, rnd());
		// Hibernation idles lines but keeps the locked rate
		hibernate = 1'b1;
		repeat (20) @(negedge sys_clk_in);
		chk(16'({tx_rdy[2:1], dev_tx}), 16'h0007, "hibernating ports");
		hibernate = 1'b0;
		repeat (4) @(negedge sys_clk_in);
		chk(16'(rate_locked), 16'h0001, "lock kept");
		chk(rate_div, 16'(HOST_DIV), "divisor kept");
		rx_frame(0, HOST_DIV, rnd());
		// A second reset returns to adaptive mode
		rst_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		rst_in = 1'b0;
		chk(16'(rate_locked), 16'h0000, "lock after reset");
		chk(rate_div, DIV_DEFAULT, "divisor after reset");
		// Lower-case line at a slower host rate locks as well
		host.send_byte(0, 8'h61, 2 * HOST_DIV);
		host.send_byte(0, 8'h74, 2 * HOST_DIV);
		repeat (40) @(negedge sys_clk_in);
		chk(16'(rate_locked), 16'h0001, "lower-case lock");
		chk(rate_div, 16'(2 * HOST_DIV), "second divisor");
		test_done();
	end

	// Watchdog: the sequence needs about 22k cycles, so 50k leaves ample margin
	initial begin
		#1_000_000;
		n_fail++;
		test_done();
	end

endmodule : testbench
